//--- src/amp_seq_pkg.sv
package amp_seq_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  ADDR_IDENT    = 8'h00;
  localparam logic [7:0]  ADDR_SYS_CTRL = 8'h04;
  localparam logic [7:0]  ADDR_SYS_STAT = 8'h08;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h10;

  // Identification value is arbitrary.
  localparam logic [15:0] IDENT_VALUE   = 16'h1234;
  localparam logic [15:0] SOFT_RESET_KEY = 16'h55AA;

  // system_control_reg fields.
  localparam int          CTRL_SYS_PD_BIT  = 0;
  localparam int          CTRL_AMP_PD_BIT  = 1;
  localparam int          CTRL_MUTE_BIT    = 2;
  localparam logic [2:0]  CTRL_RESET_VALUE = 3'h7;

  // system_status_reg fields.
  localparam int          STAT_MODE_LSB  = 0;
  localparam int          STAT_READY_BIT = 2;
  localparam int          STAT_LOCK_BIT  = 3;
  localparam int          STAT_OTP_BIT   = 4;
  localparam int          STAT_UVP_BIT   = 5;

  // Interrupt status and mask layout.
  localparam int          INT_READY_BIT  = 0;
  localparam int          INT_OTP_BIT    = 1;
  localparam int          INT_UVP_BIT    = 2;
  localparam int          INT_UNLOCK_BIT = 3;
  localparam int          INT_WIDTH      = 4;
  localparam logic [3:0]  INT_MASK_RESET = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_MHZ        = 250;
  localparam int          BOOT_TIME_NS   = 1000;
  localparam int          BOOT_CYCLES    = (BOOT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          BOOT_CNT_WIDTH = 9;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    POWER_DOWN,
    STAND_BY,
    CONFIGURING,
    OPERATING
  } mode_type;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  // Comparator outputs from the analog monitors plus the PLL lock, all asynchronous.
  typedef struct packed {
    logic digital_supply_above_por;
    logic vbat_above_por;
    logic digital_supply_ok;
    logic vbat_ok;
    logic temp_shutdown;
    logic temp_recovered;
    logic supply_undervolt;
    logic supply_released;
    logic pll_locked;
  } monitor_type;

  localparam int MON_WIDTH = $bits(monitor_type);

  typedef struct packed {
    logic bias_en;
    logic osc_pll_en;
    logic boost_en;
    logic amp_loop_en;
    logic power_stage_en;
    logic output_float;
  } power_en_type;

endpackage

//--- src/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        first_stage[i] <= 1'b0;
        sync_out[i]    <= 1'b0;
      end else begin
        first_stage[i] <= async_in[i];
        sync_out[i]    <= first_stage[i];
      end
    end
  end

endmodule

//--- src/amp_power_mode_sequencer.sv
`timescale 1ns/1ps
module amp_power_mode_sequencer (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  // APB slave
  input  wire amp_seq_pkg::apb_req_type    apb_req,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Analog monitors and PLL
  input  wire amp_seq_pkg::monitor_type    monitors,
  // Power control
  output amp_seq_pkg::power_en_type        power_en,
  output logic                             hard_mute,
  output logic                             internal_reset,
  output logic                             irq
);
  import amp_seq_pkg::*;

  // ****************************************************************
  // Monitor synchronisation
  // ****************************************************************
  logic [MON_WIDTH-1:0] mon_bits;
  monitor_type          mon;

  level_sync #(
    .WIDTH    (MON_WIDTH)
  ) u_mon_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .async_in (monitors),
    .sync_out (mon_bits)
  );

  assign mon = monitor_type'(mon_bits);

  function automatic logic [1:0] mode_code(input mode_type m);
    case (m)
      POWER_DOWN:  mode_code = 2'h0;
      STAND_BY:    mode_code = 2'h1;
      CONFIGURING: mode_code = 2'h2;
      OPERATING:   mode_code = 2'h3;
      default:     mode_code = 2'h0;
    endcase
  endfunction

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  mode_type                 mode;
  mode_type                 next_mode;
  logic [2:0]               sys_ctrl;
  logic [INT_WIDTH-1:0]     int_stat;
  logic [INT_WIDTH-1:0]     int_mask;
  logic                     ready_flag;
  logic                     otp_active;
  logic                     uvp_active;
  logic                     lock_seen;
  logic [BOOT_CNT_WIDTH-1:0] boot_cnt;
  logic                     access;
  logic                     wr_en;
  logic                     rd_en;
  logic                     soft_reset;
  logic                     bus_dead;
  logic                     supply_low;
  logic                     clear_all;
  logic [INT_WIDTH-1:0]     events;
  logic [31:0]              rd_value;
  logic                     addr_ok;

  assign access     = apb_req.psel && apb_req.penable && pready;
  assign bus_dead   = (mode == POWER_DOWN);
  assign wr_en      = access && apb_req.pwrite && !bus_dead;
  assign rd_en      = access && !apb_req.pwrite && !bus_dead;
  assign supply_low = !mon.digital_supply_above_por || !mon.vbat_above_por;

  assign soft_reset = wr_en && (apb_req.paddr == ADDR_IDENT)
                      && (apb_req.pwdata[15:0] == SOFT_RESET_KEY);
  assign clear_all  = bus_dead || soft_reset;

  always_comb begin
    addr_ok  = 1'b1;
    rd_value = 32'h0000_0000;
    case (apb_req.paddr)
      ADDR_IDENT:    rd_value[15:0] = IDENT_VALUE;
      ADDR_SYS_CTRL: rd_value[2:0]  = sys_ctrl;
      ADDR_SYS_STAT: begin
        rd_value[STAT_MODE_LSB +: 2] = mode_code(mode);
        rd_value[STAT_READY_BIT]     = ready_flag;
        rd_value[STAT_LOCK_BIT]      = mon.pll_locked;
        rd_value[STAT_OTP_BIT]       = otp_active;
        rd_value[STAT_UVP_BIT]       = uvp_active;
      end
      ADDR_INT_STAT: rd_value[INT_WIDTH-1:0] = int_stat;
      ADDR_INT_MASK: rd_value[INT_WIDTH-1:0] = int_mask;
      default:       addr_ok = 1'b0;
    endcase
  end

  // One wait-free access: pready rises in the first access cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_req.psel && !apb_req.penable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apb_req.psel && !apb_req.penable) begin
      pslverr <= bus_dead || !addr_ok
                 || (apb_req.pwrite && (apb_req.paddr == ADDR_SYS_STAT));
      prdata  <= (bus_dead || apb_req.pwrite) ? 32'h0000_0000 : rd_value;
    end
  end

  // ****************************************************************
  // Control and interrupt mask registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sys_ctrl <= CTRL_RESET_VALUE;
    end else if (clear_all) begin
      sys_ctrl <= CTRL_RESET_VALUE;
    end else if (wr_en && (apb_req.paddr == ADDR_SYS_CTRL)) begin
      sys_ctrl <= apb_req.pwdata[2:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_mask <= INT_MASK_RESET;
    end else if (clear_all) begin
      int_mask <= INT_MASK_RESET;
    end else if (wr_en && (apb_req.paddr == ADDR_INT_MASK)) begin
      int_mask <= apb_req.pwdata[INT_WIDTH-1:0];
    end
  end

  // ****************************************************************
  // Mode sequencing
  // ****************************************************************
  always_comb begin
    next_mode = mode;
    case (mode)
      POWER_DOWN: begin
        if (mon.digital_supply_ok && mon.vbat_ok) begin
          next_mode = STAND_BY;
        end
      end
      STAND_BY: begin
        if (!sys_ctrl[CTRL_SYS_PD_BIT]) begin
          next_mode = CONFIGURING;
        end
      end
      CONFIGURING: begin
        if (sys_ctrl[CTRL_SYS_PD_BIT]) begin
          next_mode = STAND_BY;
        end else if (!sys_ctrl[CTRL_AMP_PD_BIT]) begin
          next_mode = OPERATING;
        end
      end
      OPERATING: begin
        if (sys_ctrl[CTRL_SYS_PD_BIT]) begin
          next_mode = STAND_BY;
        end else if (sys_ctrl[CTRL_AMP_PD_BIT]) begin
          next_mode = CONFIGURING;
        end
      end
      default: next_mode = POWER_DOWN;
    endcase
    if (supply_low) begin
      next_mode = POWER_DOWN;
    end else if (soft_reset) begin
      next_mode = STAND_BY;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode <= POWER_DOWN;
    end else begin
      mode <= next_mode;
    end
  end

  // Boost and amplifier boot timer; a fixed wait models the start-up ramp.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_cnt   <= '0;
      ready_flag <= 1'b0;
    end else if (mode != OPERATING || next_mode != OPERATING) begin
      boot_cnt   <= '0;
      ready_flag <= 1'b0;
    end else if (boot_cnt == BOOT_CNT_WIDTH'(BOOT_CYCLES - 1)) begin
      ready_flag <= 1'b1;
    end else begin
      boot_cnt <= boot_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Protection
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      otp_active <= 1'b0;
    end else if (mon.temp_shutdown) begin
      otp_active <= 1'b1;
    end else if (mon.temp_recovered) begin
      otp_active <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      uvp_active <= 1'b0;
    end else if (mon.supply_undervolt) begin
      uvp_active <= 1'b1;
    end else if (mon.supply_released) begin
      uvp_active <= 1'b0;
    end
  end

  // Lock loss only counts once lock has been seen in this configuring run.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lock_seen <= 1'b0;
    end else if (mode == POWER_DOWN || mode == STAND_BY) begin
      lock_seen <= 1'b0;
    end else begin
      lock_seen <= mon.pll_locked;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    events                 = '0;
    events[INT_READY_BIT]  = (mode == OPERATING) && !ready_flag
                             && (boot_cnt == BOOT_CNT_WIDTH'(BOOT_CYCLES - 1))
                             && (next_mode == OPERATING);
    events[INT_OTP_BIT]    = mon.temp_shutdown && !otp_active;
    events[INT_UVP_BIT]    = mon.supply_undervolt && !uvp_active;
    events[INT_UNLOCK_BIT] = lock_seen && !mon.pll_locked;
  end

  // A read clears only the bits it reported at the setup edge, so an event
  // that lands between setup and access, or in the access cycle, survives.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      int_stat <= '0;
    end else if (clear_all) begin
      int_stat <= events;
    end else if (rd_en && (apb_req.paddr == ADDR_INT_STAT)) begin
      int_stat <= (int_stat & ~prdata[INT_WIDTH-1:0]) | events;
    end else begin
      int_stat <= int_stat | events;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ****************************************************************
  // Power enables and mute
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      internal_reset <= 1'b1;
    end else begin
      internal_reset <= (next_mode == POWER_DOWN) || soft_reset;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      power_en <= '{default: 1'b0, output_float: 1'b1};
    end else begin
      power_en.bias_en        <= (next_mode == CONFIGURING) || (next_mode == OPERATING);
      power_en.osc_pll_en     <= (next_mode == CONFIGURING) || (next_mode == OPERATING);
      power_en.boost_en       <= (next_mode == OPERATING);
      power_en.amp_loop_en    <= (next_mode == OPERATING);
      power_en.power_stage_en <= (next_mode == OPERATING) && !otp_active
                                 && !uvp_active && mon.pll_locked;
      power_en.output_float   <= (next_mode != OPERATING);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hard_mute <= 1'b1;
    end else begin
      hard_mute <= sys_ctrl[CTRL_MUTE_BIT] || !ready_flag || otp_active
                   || uvp_active || !mon.pll_locked || (next_mode != OPERATING);
    end
  end

endmodule

//--- test/amp_seq_chk.sv
`timescale 1ns/1ps
module amp_seq_chk (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  // Watched ports
  input wire amp_seq_pkg::apb_req_type apb_req,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire amp_seq_pkg::monitor_type monitors,
  input wire amp_seq_pkg::power_en_type power_en,
  input wire logic                     hard_mute,
  input wire logic                     internal_reset,
  input wire logic                     irq
);
  import amp_seq_pkg::*;
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_por_on_fall: assert property ($fell(monitors.vbat_above_por)
    || $fell(monitors.digital_supply_above_por) |-> ##[1:5] internal_reset)
    else $error("no reset after supply fell");
  a_pd_on_low: assert property (!monitors.digital_supply_above_por [*7] |->
    internal_reset && power_en == 6'h01)
    else $error("power-down not held");
  a_standby_off: assert property (!power_en.bias_en |-> power_en == 6'h01)
    else $error("module on without bias");
  a_config_float: assert property (power_en.bias_en && !power_en.boost_en |->
    power_en.osc_pll_en && power_en.output_float && !power_en.power_stage_en)
    else $error("configuring outputs wrong");
  a_stage_chain: assert property (power_en.power_stage_en |->
    power_en.boost_en && power_en.amp_loop_en && !power_en.output_float)
    else $error("stage on without boost and loop");
  a_unmute_ready: assert property ($fell(hard_mute) |-> power_en.power_stage_en)
    else $error("unmuted outside operating");
  a_mute_otp: assert property (monitors.temp_shutdown [*7] |-> hard_mute && !power_en.power_stage_en)
    else $error("no mute on over-temperature");
  a_mute_uvp: assert property (monitors.supply_undervolt [*7] |-> hard_mute)
    else $error("no mute on under-voltage");
  a_soft_reset: assert property (pready && !pslverr && apb_req.pwrite && apb_req.paddr == ADDR_IDENT
    && apb_req.pwdata[15:0] == SOFT_RESET_KEY |-> ##[1:3] internal_reset)
    else $error("no reset after key write");
  a_mute_unlock: assert property (!monitors.pll_locked [*7] |-> hard_mute && !power_en.power_stage_en)
    else $error("no mute without lock");
  c_error: cover property (pready && pslverr);
  c_stage: cover property ($rose(power_en.power_stage_en));
  c_irq: cover property ($rose(irq));
  c_unlock: cover property ($fell(monitors.pll_locked) ##3 hard_mute);
endmodule

//--- test/amp_seq_host.sv
`timescale 1ns/1ps
module amp_seq_host (
  // Clock
  input wire logic                     clk_sys,
  // Answer
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // Request
  output amp_seq_pkg::apb_req_type     apb_req
);
  import amp_seq_pkg::*;
  initial apb_req = '0;
  // Released address and data lines show the inverse so stale values never pass.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_sys);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    apb_req.paddr   <= ~a;
    apb_req.pwdata  <= ~d;
  endtask
endmodule

//--- test/amp_power_mode_sequencer_bench.sv
`timescale 1ns/1ps
module amp_power_mode_sequencer_bench;
  import amp_seq_pkg::*;
  // Lock shows only while the host keeps its audio clocks in range.
  localparam logic [8:0] GOOD = 9'h1EB;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  monitor_type  mon = '0;
  apb_req_type  apb_req;
  power_en_type power_en;
  logic [31:0]  prdata, q;
  logic         pready, pslverr, hard_mute, internal_reset, irq, e;
  int           errors = 0;
  int           cmp_count = 0;
  int           seed = 43301;
  int           mask_m, r;
  always #2 clk_sys = ~clk_sys;
  amp_power_mode_sequencer i_amp_power_mode_sequencer (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitors(mon), .power_en(power_en),
    .hard_mute(hard_mute), .internal_reset(internal_reset), .irq(irq));
  amp_seq_host i_amp_seq_host (.clk_sys(clk_sys), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .apb_req(apb_req));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic get(input logic [7:0] a);
    i_amp_seq_host.xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ex);
    get(a);
    chk({e, q}, {ex, x});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ex);
    i_amp_seq_host.xfer(1'b1, a, d, q, e);
    chk(e, ex);
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  // ****
  // Sequence
  // ****
  initial begin
    tick(12);
    chk({internal_reset, hard_mute, power_en}, 8'hC1);
    @(posedge clk_sys) rst_n <= 1'b1;
    tick(8);
    chk(internal_reset, 1'b1);
    @(posedge clk_sys) mon <= GOOD;
    tick(8);
    chk({internal_reset, power_en}, 7'h01);
    rd(ADDR_IDENT, IDENT_VALUE, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
    rd(ADDR_SYS_CTRL, CTRL_RESET_VALUE, 1'b0);
    for (int i = 0; i < 4; i++) begin
      mask_m = $random(seed) & 15;
      wr(ADDR_INT_MASK, mask_m, 1'b0);
      rd(ADDR_INT_MASK, mask_m, 1'b0);
    end
    wr(ADDR_INT_MASK, 32'hF, 1'b0);
    // The system is enabled first and the amplifier only after lock shows.
    wr(ADDR_SYS_CTRL, 32'h6, 1'b0);
    tick(2);
    chk(power_en, 6'h31);
    rd(ADDR_SYS_STAT, 32'h0A, 1'b0);
    wr(ADDR_SYS_CTRL, 32'h4, 1'b0);
    tick(2);
    chk(power_en, 6'h3E);
    r = 0;
    do begin get(ADDR_SYS_STAT); r++; end while (q[STAT_READY_BIT] !== 1'b1 && r < 200);
    chk(q, 32'h0F);
    tick(2);
    chk({hard_mute, irq}, 2'b11);
    rd(ADDR_INT_STAT, 32'h1, 1'b0);
    tick(2);
    chk(irq, 1'b0);
    wr(ADDR_SYS_CTRL, 32'h0, 1'b0);
    tick(3);
    chk(hard_mute, 1'b0);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) wr(ADDR_INT_MASK, 32'h0, 1'b0);
      @(posedge clk_sys) begin mon[4-2*p] <= 1'b1; mon[3-2*p] <= 1'b0; end
      tick(8);
      chk({hard_mute, power_en.power_stage_en, irq}, {2'b10, p == 0});
      @(posedge clk_sys) mon[4-2*p] <= 1'b0;
      tick(8);
      get(ADDR_SYS_STAT);
      chk({q[STAT_OTP_BIT+p], hard_mute}, 2'b11);
      get(ADDR_INT_STAT);
      chk(q[INT_OTP_BIT+p], 1'b1);
      @(posedge clk_sys) mon[3-2*p] <= 1'b1;
      tick(8);
      get(ADDR_SYS_STAT);
      chk({q[STAT_OTP_BIT+p], hard_mute}, 2'b00);
    end
    @(posedge clk_sys) mon[0] <= 1'b0;
    tick(8);
    chk({hard_mute, power_en.power_stage_en}, 2'b10);
    rd(ADDR_INT_STAT, 32'h8, 1'b0);
    @(posedge clk_sys) mon[0] <= 1'b1;
    tick(8);
    chk({hard_mute, power_en.power_stage_en}, 2'b01);
    wr(ADDR_SYS_STAT, 32'h0, 1'b1);
    wr(ADDR_IDENT, {16'h0, SOFT_RESET_KEY}, 1'b0);
    tick(4);
    chk(power_en, 6'h01);
    rd(ADDR_SYS_CTRL, CTRL_RESET_VALUE, 1'b0);
    rd(ADDR_INT_MASK, INT_MASK_RESET, 1'b0);
    @(posedge clk_sys) mon <= 9'h0AB;
    tick(8);
    chk({internal_reset, power_en}, 7'h41);
    rd(ADDR_IDENT, 32'h0, 1'b1);
    @(posedge clk_sys) mon <= GOOD;
    tick(8);
    chk(internal_reset, 1'b0);
    rd(ADDR_SYS_CTRL, CTRL_RESET_VALUE, 1'b0);
    print_verdict();
  end
endmodule
bind amp_power_mode_sequencer amp_seq_chk i_amp_seq_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitors(monitors),
  .power_en(power_en), .hard_mute(hard_mute), .internal_reset(internal_reset), .irq(irq));
